//--- bench/sld_host.sv
// Controller model driving the serial pins
`timescale 1ns/1ps
module sld_host (input wire logic core_clk, output logic shift_clk, serial_in, latch_transfer, out_disable);
  initial {shift_clk, serial_in, latch_transfer, out_disable} = 4'h0;
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge core_clk) serial_in = b[i];
      repeat (13) @(negedge core_clk);
      shift_clk = 1'h1;
      repeat (13) @(negedge core_clk);
      shift_clk = 1'h0;
    end
  endtask
  task automatic strobe;
    repeat (26) @(negedge core_clk);
    latch_transfer = 1'h1;
    repeat (13) @(negedge core_clk);
    latch_transfer = 1'h0;
  endtask
endmodule // sld_host

//--- bench/sld_monitor.sv
// Checker on the sink driver ports
`timescale 1ns/1ps
module sld_monitor #(parameter int STAGES = 8) (input wire logic core_clk, arst_n, shift_clk, serial_in,
  input wire logic latch_transfer, out_disable, serial_out, input wire logic [STAGES-1:0] sink_on);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_low; !shift_clk[*8]; endsequence
  a_rst_clear: assert property (disable iff (1'h0) !arst_n |-> !sink_on && !serial_out) else $error("reset");
  a_dis_off: assert property (out_disable[*4] |=> !sink_on) else $error("gate");
  a_hold_lo: assert property (s_low |-> $stable(serial_out)) else $error("hold");
  a_hold_hi: assert property (shift_clk[*8] |-> $stable(serial_out)) else $error("hold");
  a_latch_hold: assert property ((!latch_transfer && !out_disable)[*6] |-> $stable(sink_on)) else $error("latch");
  a_latch_copy: assert property ((latch_transfer && !out_disable)[*8] and s_low |->
    sink_on[STAGES-1] == serial_out) else $error("copy");
  a_shift_cause: assert property ($changed(serial_out) |-> $past(shift_clk, 3)) else $error("shift");
  a_dis_cause: assert property (|sink_on |-> !$past(out_disable, 3)) else $error("enable");
endmodule // sld_monitor
bind sld_driver sld_monitor #(.STAGES(STAGES)) u_mon (.core_clk, .arst_n, .shift_clk, .serial_in,
  .latch_transfer, .out_disable, .serial_out, .sink_on);

//--- bench/test_serial_in_latched_output_driver.sv
// Self-checking bench for the sink driver
`timescale 1ns/1ps
module test_serial_in_latched_output_driver;
  logic core_clk = 1'h0, arst_n = 1'h0, shift_clk, serial_in, latch_transfer, out_disable, serial_out;
  logic [7:0] sink_on, b;
  logic [8:0] exp_q[$];
  logic [31:0] rng = 32'h0000E769;
  int n_mismatch = 0, samples_checked = 0;
  event got;
  always #2 core_clk = ~core_clk;
  sld_host u_host (.core_clk, .shift_clk, .serial_in, .latch_transfer, .out_disable);
  sld_driver DUT (.core_clk, .arst_n, .shift_clk, .serial_in, .latch_transfer, .out_disable, .serial_out, .sink_on);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic check(input logic [8:0] seen, want);
    samples_checked++;
    if (seen !== want) n_mismatch++;
    if (seen !== want) $display("unexpected outputs: expected %h seen %h", want, seen);
  endtask
  task automatic note(input logic [8:0] want);
    repeat (8) @(negedge core_clk);
    exp_q.push_back(want);
    ->got;
  endtask
  always @(got) check({serial_out, sink_on}, exp_q.pop_front());
  task automatic results;
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #40000 n_mismatch++;
    results();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    arst_n = 1'h1;
    note(9'h000);
    repeat (4) begin
      rng = xs(rng);
      b = rng[7:0];
      u_host.send(b);
      u_host.strobe();
      note({b[7], b});
    end
    u_host.send(~b);
    note({~b[7], b});
    u_host.out_disable = 1'h1;
    note({~b[7], 8'h00});
    u_host.out_disable = 1'h0;
    note({~b[7], b});
    u_host.out_disable = 1'h1;
    u_host.latch_transfer = 1'h1;
    u_host.send(b);
    note({b[7], 8'h00});
    u_host.out_disable = 1'h0;
    note({b[7], b});
    u_host.latch_transfer = 1'h0;
    @(negedge core_clk);
    results();
  end
endmodule // test_serial_in_latched_output_driver

//--- rtl/sld_driver.sv
// Serial-in shift register with transfer latches and gated sink outputs
`timescale 1ns/1ps
module sld_driver #(
  parameter int STAGES = sld_pkg::STAGES
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  // Serial control pins from the controller (asynchronous)
  input  wire logic              shift_clk,
  input  wire logic              serial_in,
  input  wire logic              latch_transfer,
  input  wire logic              out_disable,
  // Chained serial output
  output logic                   serial_out,
  // Sink outputs: bit 0 is sink_output_first, top bit sink_output_last
  output logic [STAGES-1:0]      sink_on
);

  // ----------------------------------------------------------------
  // Pin numbering inside the synchroniser
  // ----------------------------------------------------------------
  // Bit order of the synchroniser vectors.
  localparam int PINS        = 4;
  localparam int PIN_CLK     = 0;
  localparam int PIN_DATA    = 1;
  localparam int PIN_STROBE  = 2;
  localparam int PIN_DISABLE = 3;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin gets the same two flops, so relative pin timing is kept.
  logic [PINS-1:0] pin_async;
  logic [PINS-1:0] sync1_q;
  logic [PINS-1:0] sync2_q;

  assign pin_async[PIN_CLK]     = shift_clk;
  assign pin_async[PIN_DATA]    = serial_in;
  assign pin_async[PIN_STROBE]  = latch_transfer;
  assign pin_async[PIN_DISABLE] = out_disable;

  for (genvar p = 0; p < PINS; p++) begin : g_sync
    // Stage 1 is read only by stage 2.
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sync1_q[p] <= 1'b0;
      end else begin
        sync1_q[p] <= pin_async[p];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sync2_q[p] <= 1'b0;
      end else begin
        sync2_q[p] <= sync1_q[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Synchronised pin levels
  // ----------------------------------------------------------------
  // Only these names are read past the synchroniser.
  logic clk_level;
  logic data_level;
  logic strobe_level;
  logic disable_level;

  assign clk_level     = sync2_q[PIN_CLK];
  assign data_level    = sync2_q[PIN_DATA];
  assign strobe_level  = sync2_q[PIN_STROBE];
  assign disable_level = sync2_q[PIN_DISABLE];

  // ----------------------------------------------------------------
  // Shift clock edge detector
  // ----------------------------------------------------------------
  // Resets to the idle low level of the pin, so reset makes no false edge.
  logic clk_prev_q;
  logic shift_rise;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_level;
    end
  end

  // Data travels the same two flops as the clock, so its set-up is kept.
  assign shift_rise = clk_level & ~clk_prev_q;

  // ----------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------
  logic [STAGES-1:0] shift_q;
  logic [STAGES-1:0] shift_d;
  logic [STAGES-1:0] stage_in;

  for (genvar s = 0; s < STAGES; s++) begin : g_shift
    logic rst_val;

    assign rst_val = sld_pkg::SHIFT_RESET[s];

    // Stage 1 takes the pin, later stages the stage before.
    if (s == 0) begin : g_first
      assign stage_in[s] = data_level;
    end else begin : g_next
      assign stage_in[s] = shift_q[s-1];
    end

    // Without a rising edge every stage keeps its content.
    always_comb begin
      if (shift_rise) begin
        shift_d[s] = stage_in[s];
      end else begin
        shift_d[s] = shift_q[s];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        shift_q[s] <= rst_val;
      end else begin
        shift_q[s] <= shift_d[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // Chained serial output
  // ----------------------------------------------------------------
  // Taken from the next value of the last stage, so it never lags it.
  logic serial_out_d;

  assign serial_out_d = shift_d[STAGES-1];

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out <= sld_pkg::SHIFT_RESET[STAGES-1];
    end else begin
      serial_out <= serial_out_d;
    end
  end

  // ----------------------------------------------------------------
  // Transfer latches
  // ----------------------------------------------------------------
  // Transparent latch modelled as a follower register, one cycle behind its stage.
  // The lag is far shorter than any legal strobe pulse.
  logic [STAGES-1:0] latch_q;
  logic [STAGES-1:0] latch_d;

  for (genvar l = 0; l < STAGES; l++) begin : g_latch
    logic rst_val;

    assign rst_val = sld_pkg::LATCH_RESET[l];

    always_comb begin
      if (strobe_level) begin
        latch_d[l] = shift_q[l];
      end else begin
        latch_d[l] = latch_q[l];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        latch_q[l] <= rst_val;
      end else begin
        latch_q[l] <= latch_d[l];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output gate
  // ----------------------------------------------------------------
  // Disable only gates the drivers; latch and shift state are untouched.
  // Registered so that the sink pins never glitch.
  logic [STAGES-1:0] sink_d;

  for (genvar o = 0; o < STAGES; o++) begin : g_gate
    logic off_val;

    assign off_val = sld_pkg::SINK_OFF[o];

    always_comb begin
      if (disable_level) begin
        sink_d[o] = off_val;
      end else begin
        sink_d[o] = latch_q[o];
      end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        sink_on[o] <= off_val;
      end else begin
        sink_on[o] <= sink_d[o];
      end
    end
  end

endmodule // sld_driver

//--- rtl/sld_pkg.sv
// Package: constants for the serial-in latched sink driver
package sld_pkg;
  // ----------------------------------------------------------------
  // Geometry and reset values
  // ----------------------------------------------------------------
  localparam int          STAGES      = 8;
  localparam logic [7:0]  SHIFT_RESET = 8'h00;
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [7:0]  SINK_OFF    = 8'h00;
  // ----------------------------------------------------------------
  // Timing of the controlling party (for reference by checkers)
  // ----------------------------------------------------------------
  localparam int          CORE_CLK_PERIOD_PS   = 4000;
  localparam int          STROBE_SETUP_NS      = 100;
  localparam int          STROBE_SETUP_CYCLES  = (STROBE_SETUP_NS * 1000 + CORE_CLK_PERIOD_PS - 1)
                                                 / CORE_CLK_PERIOD_PS;
  localparam int          SHIFT_CLK_MAX_KHZ    = 10000;
endpackage : sld_pkg
